// ### include/pdac_pkg.sv
package pdac_pkg;
   localparam int DIGITS = 10;
   localparam int DIGIT_W = 4;
   localparam int NUM_W = DIGITS * DIGIT_W;
   localparam logic [NUM_W-1:0] NUM_RST = 40'h0000000000;

   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_PRIM = 8'h04;
   localparam logic [7:0] OFS_HUNT = 8'h08;
   localparam logic [7:0] OFS_XPRIM = 8'h0C;
   localparam logic [7:0] OFS_XHUNT = 8'h10;
   localparam logic [7:0] OFS_XADD = 8'h14;
   localparam logic [7:0] OFS_STAT = 8'h18;
   localparam logic [7:0] OFS_IRQ = 8'h1C;
   localparam logic [7:0] OFS_MASK = 8'h20;
   localparam logic [7:0] OFS_LOAD = 8'h24;
   localparam logic [7:0] OFS_PROF = 8'h28;
   localparam logic [7:0] OFS_CALLING = 8'h2C;

   localparam int CTRL_AUTO = 0;
   localparam int CTRL_TRIG_LO = 1;
   localparam int CTRL_ESC_LO = 4;
   localparam int CTRL_TMO_LO = 8;
   localparam int CTRL_DIAL = 16;
   localparam int CTRL_HANG = 17;

   localparam logic [5:0] TMO_MIN = 6'h01;
   localparam logic [5:0] TMO_MAX = 6'h3C;
   localparam logic [5:0] TMO_RST = 6'h01;
   localparam int CLK_HZ = 50000000;
   localparam int SEC_NS = 1000000000;
   localparam int CLK_NS = SEC_NS / CLK_HZ;
   localparam int SEC_CYC = SEC_NS / CLK_NS;

   localparam int EV_LOADED = 0;
   localparam int EV_ANSWER = 1;
   localparam int EV_TIMEOUT = 2;
   localparam int EV_DIALED = 3;
   localparam int EV_REFUSED = 4;
   localparam int EV_W = 5;

   typedef enum logic [1:0] {TRIG_OFF, TRIG_DTR, TRIG_SER, TRIG_V25} pdac_trig_t;
   typedef enum logic [2:0] {
      ESC_STAR, ESC_HASH, ESC_5, ESC_6, ESC_7, ESC_9, ESC_0, ESC_00
   } pdac_esc_t;

   typedef struct packed {
      logic valid;
      logic imux;
      logic [NUM_W-1:0] number;
   } pdac_call_t;

   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } pdac_bus_t;
endpackage

// ### src/pdac_sync.sv
`timescale 1ns/1ns
module pdac_sync #(
   parameter int W = 1
) (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_q;

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         meta_q <= '0;
         q <= '0;
      end else begin
         meta_q <= d;
         q <= meta_q;
      end
   end
endmodule

// ### src/pdac_port.sv
// The register offsets and the address-and-strobe port were decided locally.
`timescale 1ns/1ns
module pdac_port #(
   parameter int SEC_CYCLES = pdac_pkg::SEC_CYC,
   parameter int PROF_W = 32
) (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire pdac_pkg::pdac_bus_t bus,
   output logic [31:0] rdata_q,
   input wire pdac_pkg::pdac_call_t call_in,
   input wire logic engine_free,
   input wire logic prior_port_free,
   input wire logic [PROF_W-1:0] tmpl_data,
   input wire logic dtr_pin,
   input wire logic ser_dial_cmd,
   input wire logic v25_dial_cmd,
   output logic call_accept_q,
   output logic call_reject_q,
   output logic ring_q,
   output logic dial_q,
   output logic hangup_q,
   output logic [pdac_pkg::NUM_W-1:0] calling_num_q,
   output logic [pdac_pkg::NUM_W-1:0] sync_add_num_q,
   output logic sync_add_valid_q,
   output logic port_free_q,
   output logic irq_q
);
   typedef enum logic [1:0] {ST_IDLE, ST_OFFER, ST_ACTIVE} pdac_state_t;

   pdac_state_t state_q;
   logic [pdac_pkg::NUM_W-1:0] prim_q;
   logic [pdac_pkg::NUM_W-1:0] hunt_q;
   logic [pdac_pkg::NUM_W-1:0] xprim_q;
   logic [pdac_pkg::NUM_W-1:0] xhunt_q;
   logic [pdac_pkg::NUM_W-1:0] xadd_q;
   logic auto_q;
   pdac_pkg::pdac_trig_t trig_q;
   pdac_pkg::pdac_esc_t esc_q;
   logic [5:0] tmo_q;
   logic loaded_q;
   logic [PROF_W-1:0] prof_q;
   logic [pdac_pkg::EV_W-1:0] irq_stat_q;
   logic [pdac_pkg::EV_W-1:0] irq_mask_q;
   logic [pdac_pkg::EV_W-1:0] ev;
   logic [31:0] sec_cnt_q;
   logic [5:0] wait_q;
   logic dtr_s;
   logic ser_s;
   logic v25_s;
   logic dtr_prev_q;
   logic ser_prev_q;
   logic v25_prev_q;
   logic dtr_rise;
   logic ser_rise;
   logic v25_rise;
   logic is_prim;
   logic is_group;
   logic offer_ok;
   logic trigger;
   logic dial_req;
   logic hang_req;
   logic free_now;
   logic offer_imux_q;

   pdac_sync #(.W(3)) u_sync (
      .clk_sys(clk_sys),
      .reset_n(reset_n),
      .d({dtr_pin, ser_dial_cmd, v25_dial_cmd}),
      .q({dtr_s, ser_s, v25_s})
   );

   // edge registers reset to the idle low level, so no false edge follows reset
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         dtr_prev_q <= 1'b0;
         ser_prev_q <= 1'b0;
         v25_prev_q <= 1'b0;
      end else begin
         dtr_prev_q <= dtr_s;
         ser_prev_q <= ser_s;
         v25_prev_q <= v25_s;
      end
   end

   assign dtr_rise = dtr_s & ~dtr_prev_q;
   assign ser_rise = ser_s & ~ser_prev_q;
   assign v25_rise = v25_s & ~v25_prev_q;

   wire wr_ctrl = bus.wr && bus.addr == pdac_pkg::OFS_CTRL;
   assign dial_req = wr_ctrl && bus.wdata[pdac_pkg::CTRL_DIAL];
   assign hang_req = wr_ctrl && bus.wdata[pdac_pkg::CTRL_HANG];
   wire load_req = bus.wr && bus.addr == pdac_pkg::OFS_LOAD;

   // configuration registers; clamped timeout keeps the wait in 1..60
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         prim_q <= pdac_pkg::NUM_RST;
         hunt_q <= pdac_pkg::NUM_RST;
         xprim_q <= pdac_pkg::NUM_RST;
         xhunt_q <= pdac_pkg::NUM_RST;
         xadd_q <= pdac_pkg::NUM_RST;
         auto_q <= 1'b1;
         trig_q <= pdac_pkg::TRIG_OFF;
         esc_q <= pdac_pkg::ESC_STAR;
         tmo_q <= pdac_pkg::TMO_RST;
      end else if (bus.wr) begin
         unique case (bus.addr)
            pdac_pkg::OFS_CTRL: begin
               auto_q <= bus.wdata[pdac_pkg::CTRL_AUTO];
               trig_q <= pdac_pkg::pdac_trig_t'(bus.wdata[pdac_pkg::CTRL_TRIG_LO +: 2]);
               esc_q <= pdac_pkg::pdac_esc_t'(bus.wdata[pdac_pkg::CTRL_ESC_LO +: 3]);
               if (bus.wdata[pdac_pkg::CTRL_TMO_LO +: 6] < pdac_pkg::TMO_MIN) begin
                  tmo_q <= pdac_pkg::TMO_MIN;
               end else if (bus.wdata[pdac_pkg::CTRL_TMO_LO +: 6] > pdac_pkg::TMO_MAX) begin
                  tmo_q <= pdac_pkg::TMO_MAX;
               end else begin
                  tmo_q <= bus.wdata[pdac_pkg::CTRL_TMO_LO +: 6];
               end
            end
            // digits 8 and 9 repeat the low byte: only eight digits are set on their own
            pdac_pkg::OFS_PRIM: prim_q <= {bus.wdata[7:0], bus.wdata[31:0]};
            pdac_pkg::OFS_HUNT: hunt_q <= {bus.wdata[7:0], bus.wdata[31:0]};
            pdac_pkg::OFS_XPRIM: xprim_q <= {bus.wdata[7:0], bus.wdata[31:0]};
            pdac_pkg::OFS_XHUNT: xhunt_q <= {bus.wdata[7:0], bus.wdata[31:0]};
            pdac_pkg::OFS_XADD: xadd_q <= {bus.wdata[7:0], bus.wdata[31:0]};
            default: ;
         endcase
      end
   end

   // profile copy: the template word is captured whole in one cycle
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         loaded_q <= 1'b0;
         prof_q <= '0;
         calling_num_q <= pdac_pkg::NUM_RST;
      end else if (load_req) begin
         loaded_q <= 1'b1;
         prof_q <= tmpl_data;
         calling_num_q <= prim_q;
      end
   end

   // address match for incoming calls
   always_comb begin
      is_prim = call_in.imux ? (call_in.number == xprim_q) : (call_in.number == prim_q);
      is_group = call_in.imux ? (call_in.number == xhunt_q) : (call_in.number == hunt_q);
   end

   // a group call is taken only if no earlier port in the chain is free
   assign free_now = state_q == ST_IDLE;
   always_comb begin
      offer_ok = 1'b0;
      if (call_in.valid && free_now) begin
         if (is_prim) begin
            offer_ok = !call_in.imux || engine_free;
         end else if (is_group && !prior_port_free) begin
            offer_ok = !call_in.imux || engine_free;
         end
      end
   end

   always_comb begin
      unique case (trig_q)
         pdac_pkg::TRIG_OFF: trigger = 1'b0;
         pdac_pkg::TRIG_DTR: trigger = dtr_rise;
         pdac_pkg::TRIG_SER: trigger = ser_rise;
         pdac_pkg::TRIG_V25: trigger = v25_rise;
      endcase
   end

   wire want_dial = trigger || dial_req;
   // an offered call wins over a dial request in the same cycle
   wire can_dial = want_dial && loaded_q && free_now && !offer_ok;

   // call state; second tick counts the answer wait
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         state_q <= ST_IDLE;
         sec_cnt_q <= '0;
         wait_q <= '0;
      end else begin
         unique case (state_q)
            ST_IDLE: begin
               if (offer_ok && auto_q) begin
                  state_q <= ST_ACTIVE;
               end else if (offer_ok) begin
                  state_q <= ST_OFFER;
                  sec_cnt_q <= '0;
                  wait_q <= tmo_q;
               end else if (can_dial) begin
                  state_q <= ST_ACTIVE;
               end
            end
            ST_OFFER: begin
               // dtr is taken as a level: a dte that already holds it up answers at once
               if (dtr_s) begin
                  state_q <= ST_ACTIVE;
               end else if (hang_req) begin
                  state_q <= ST_IDLE;
               end else if (sec_cnt_q == 32'(SEC_CYCLES - 1)) begin
                  sec_cnt_q <= '0;
                  if (wait_q == 6'h01) begin
                     state_q <= ST_IDLE;
                  end
                  wait_q <= wait_q - 6'h01;
               end else begin
                  sec_cnt_q <= sec_cnt_q + 32'h00000001;
               end
            end
            ST_ACTIVE: begin
               if (hang_req) begin
                  state_q <= ST_IDLE;
               end
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   wire tmo_ev = state_q == ST_OFFER && !dtr_s && !hang_req && wait_q == 6'h01 &&
      sec_cnt_q == 32'(SEC_CYCLES - 1);
   wire ans_ev = (state_q == ST_IDLE && offer_ok && auto_q) || (state_q == ST_OFFER && dtr_s);
   // rejected calls: any addressed call we cannot take while busy, without engine, or as a group call left to a free earlier port
   wire rej_ev = call_in.valid && (is_prim || is_group) && !offer_ok;

   // call-control outputs
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         call_accept_q <= 1'b0;
         call_reject_q <= 1'b0;
         ring_q <= 1'b0;
         dial_q <= 1'b0;
         hangup_q <= 1'b0;
         port_free_q <= 1'b1;
      end else begin
         call_accept_q <= ans_ev;
         call_reject_q <= rej_ev || tmo_ev;
         ring_q <= (state_q == ST_IDLE && offer_ok && !auto_q) ||
            (state_q == ST_OFFER && !dtr_s && !hang_req && !tmo_ev);
         dial_q <= can_dial;
         hangup_q <= hang_req && state_q != ST_IDLE;
         port_free_q <= state_q == ST_IDLE && !offer_ok && !can_dial;
      end
   end

   // a manual answer comes after call_in has gone, so the imux case is kept
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         offer_imux_q <= 1'b0;
      end else if (state_q == ST_IDLE && offer_ok) begin
         offer_imux_q <= call_in.imux && is_prim;
      end
   end

   wire imux_answer = state_q == ST_IDLE ? call_in.imux && is_prim : offer_imux_q;

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         sync_add_num_q <= pdac_pkg::NUM_RST;
         sync_add_valid_q <= 1'b0;
      end else if (ans_ev && imux_answer) begin
         // zero add number means primary-only sync
         sync_add_num_q <= xadd_q;
         sync_add_valid_q <= xadd_q != pdac_pkg::NUM_RST;
      end else if (state_q == ST_IDLE) begin
         sync_add_valid_q <= 1'b0;
      end
   end

   assign ev[pdac_pkg::EV_LOADED] = load_req;
   assign ev[pdac_pkg::EV_ANSWER] = ans_ev;
   assign ev[pdac_pkg::EV_TIMEOUT] = tmo_ev;
   assign ev[pdac_pkg::EV_DIALED] = can_dial;
   assign ev[pdac_pkg::EV_REFUSED] = want_dial && !can_dial;

   // sticky status: a new event beats a simultaneous write-one clear
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         irq_stat_q <= '0;
         irq_q <= 1'b0;
      end else begin
         if (bus.wr && bus.addr == pdac_pkg::OFS_IRQ) begin
            irq_stat_q <= (irq_stat_q & ~bus.wdata[pdac_pkg::EV_W-1:0]) | ev;
         end else begin
            irq_stat_q <= irq_stat_q | ev;
         end
         irq_q <= |(irq_stat_q & irq_mask_q);
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         irq_mask_q <= '0;
      end else if (bus.wr && bus.addr == pdac_pkg::OFS_MASK) begin
         irq_mask_q <= bus.wdata[pdac_pkg::EV_W-1:0];
      end
   end

   // read port: data valid in the cycle after the strobe only
   always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
         rdata_q <= '0;
      end else if (bus.rd) begin
         unique case (bus.addr)
            pdac_pkg::OFS_CTRL: rdata_q <= {18'h00000, tmo_q, 1'b0, esc_q, 1'b0, trig_q, auto_q};
            pdac_pkg::OFS_PRIM: rdata_q <= prim_q[31:0];
            pdac_pkg::OFS_HUNT: rdata_q <= hunt_q[31:0];
            pdac_pkg::OFS_XPRIM: rdata_q <= xprim_q[31:0];
            pdac_pkg::OFS_XHUNT: rdata_q <= xhunt_q[31:0];
            pdac_pkg::OFS_XADD: rdata_q <= xadd_q[31:0];
            pdac_pkg::OFS_STAT: rdata_q <= {28'h0000000, dtr_s, loaded_q, 2'(state_q)};
            pdac_pkg::OFS_IRQ: rdata_q <= {27'h0000000, irq_stat_q};
            pdac_pkg::OFS_MASK: rdata_q <= {27'h0000000, irq_mask_q};
            pdac_pkg::OFS_PROF: rdata_q <= 32'(prof_q);
            pdac_pkg::OFS_CALLING: rdata_q <= calling_num_q[31:0];
            default: rdata_q <= 32'h00000000;
         endcase
      end else begin
         rdata_q <= 32'h00000000;
      end
   end
endmodule

// ### testbench/pdac_port_props.sv
`timescale 1ns/1ns
module pdac_port_props #(
   parameter int SEC_CYCLES = 10
) (
   input wire logic clk_sys,
   input wire logic reset_n,
   input wire logic dtr_pin,
   input wire logic call_accept_q,
   input wire logic call_reject_q,
   input wire logic ring_q,
   input wire logic dial_q,
   input wire logic hangup_q,
   input wire logic port_free_q
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   // wide enough for sixty-one seconds at the full clock rate
   localparam longint RING_MAX = 64'(61) * 64'(SEC_CYCLES);
   longint ring_cnt_q;
   // counts offer length so the answer wait can be bounded
   always_ff @(posedge clk_sys) begin
      if (!reset_n || !ring_q) ring_cnt_q <= 0;
      else ring_cnt_q <= ring_cnt_q + 1;
   end
   sequence s_wait_low;
      ring_q && !dtr_pin ##1 !dtr_pin [*3];
   endsequence
   a_dial_once: assert property (dial_q |=> !dial_q [*3])
      else $error("dial pulse repeated");
   a_dial_from_idle: assert property (dial_q |->
      $past(port_free_q) || $past(hangup_q) || $past(call_reject_q))
      else $error("dial while busy");
   a_dial_busy: assert property (dial_q |=> !port_free_q)
      else $error("port still free after dial");
   a_accept_busy: assert property (call_accept_q |=> !port_free_q)
      else $error("port still free after answer");
   a_accept_pulse: assert property (call_accept_q |=> !call_accept_q)
      else $error("answer pulse too long");
   a_hold_no_dtr: assert property (s_wait_low |-> !call_accept_q)
      else $error("answered without dtr");
   a_dtr_answers: assert property (ring_q && dtr_pin |-> ##[0:6] call_accept_q)
      else $error("dtr did not answer");
   a_ring_bound: assert property (ring_cnt_q <= RING_MAX)
      else $error("offer outlived the wait");
   a_ring_ends: assert property ($fell(ring_q) |-> call_accept_q || call_reject_q || hangup_q)
      else $error("ring dropped without answer, timeout or hangup");
endmodule
bind pdac_port pdac_port_props #(.SEC_CYCLES(SEC_CYCLES)) u_pdac_port_props (
   .clk_sys(clk_sys), .reset_n(reset_n), .dtr_pin(dtr_pin),
   .call_accept_q(call_accept_q), .call_reject_q(call_reject_q),
   .ring_q(ring_q), .dial_q(dial_q), .hangup_q(hangup_q), .port_free_q(port_free_q)
);

// ### testbench/pdac_dte.sv
`timescale 1ns/1ns
module pdac_dte (
   input wire logic clk_sys,
   input wire logic [1:0] act,
   input wire logic go,
   input wire logic dtr_drop,
   output logic dtr_pin,
   output logic ser_dial_cmd,
   output logic v25_dial_cmd
);
   logic [1:0] kind_q = 2'h0;
   logic [2:0] hold_q = 3'h0;
   initial dtr_pin = 1'b0;
   // commands held long enough to pass the two-stage synchroniser
   always @(posedge clk_sys) begin
      if (go) begin
         kind_q <= act;
         hold_q <= 3'h6;
      end else if (hold_q != 3'h0) hold_q <= hold_q - 3'h1;
      if (dtr_drop) dtr_pin <= 1'b0;
      else if (go && act == 2'h1) dtr_pin <= 1'b1;
   end
   assign ser_dial_cmd = hold_q != 3'h0 && kind_q == 2'h2;
   assign v25_dial_cmd = hold_q != 3'h0 && kind_q == 2'h3;
endmodule

// ### testbench/tb_pdac_port.sv
`timescale 1ns/1ns
module tb_pdac_port;
   localparam int SEC = 10;
   logic clk_sys = 1'b0;
   logic reset_n = 1'b0;
   pdac_pkg::pdac_bus_t bus = '0;
   pdac_pkg::pdac_call_t call_in = '0;
   logic engine_free = 1'b0;
   logic prior_port_free = 1'b0;
   logic [31:0] tmpl_data = 32'h0;
   logic [1:0] act = 2'h0;
   logic go = 1'b0;
   logic dtr_drop = 1'b0;
   logic dtr_pin, ser_dial_cmd, v25_dial_cmd, call_accept_q, call_reject_q, ring_q;
   logic dial_q, hangup_q, sync_add_valid_q, port_free_q, irq_q;
   logic [31:0] rdata_q;
   logic [39:0] calling_num_q, sync_add_num_q;
   logic [31:0] seed = 32'h37;
   int n_mismatch = 0;
   int n_checks = 0;
   int n_acc = 0;
   int n_dial = 0;
   int n_rej = 0;
   int n_hang = 0;
   int cyc = 0;
   pdac_port #(.SEC_CYCLES(SEC)) u_pdac_port (.clk_sys(clk_sys), .reset_n(reset_n),
      .bus(bus), .rdata_q(rdata_q), .call_in(call_in), .engine_free(engine_free),
      .prior_port_free(prior_port_free), .tmpl_data(tmpl_data), .dtr_pin(dtr_pin),
      .ser_dial_cmd(ser_dial_cmd), .v25_dial_cmd(v25_dial_cmd),
      .call_accept_q(call_accept_q), .call_reject_q(call_reject_q), .ring_q(ring_q),
      .dial_q(dial_q), .hangup_q(hangup_q), .calling_num_q(calling_num_q),
      .sync_add_num_q(sync_add_num_q), .sync_add_valid_q(sync_add_valid_q),
      .port_free_q(port_free_q), .irq_q(irq_q));
   pdac_dte u_pdac_dte (.clk_sys(clk_sys), .act(act), .go(go), .dtr_drop(dtr_drop),
      .dtr_pin(dtr_pin), .ser_dial_cmd(ser_dial_cmd), .v25_dial_cmd(v25_dial_cmd));
   initial begin
      forever #10 clk_sys = ~clk_sys;
   end
   task automatic end_of_test();
      if (n_mismatch == 0 && n_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   always @(posedge clk_sys) begin
      cyc++;
      n_acc += int'(call_accept_q);
      n_dial += int'(dial_q);
      n_rej += int'(call_reject_q);
      n_hang += int'(hangup_q);
      if (cyc == 5000) begin
         n_mismatch++;
         end_of_test();
      end
   end
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic [31:0] bcd();
      logic [31:0] v;
      v = 32'h0;
      for (int i = 0; i < 8; i++) v[i*4+:4] = 4'(rnd() % 10);
      return v;
   endfunction
   task automatic chk(input logic [39:0] got, input logic [39:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk_sys);
      bus <= '0;
      @(posedge clk_sys);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
      @(posedge clk_sys);
      bus <= '0;
      #1 chk({8'h0, rdata_q}, {8'h0, exp});
      @(posedge clk_sys);
   endtask
   task automatic call(input logic im, input logic [31:0] w);
      call_in <= '{valid: 1'b1, imux: im, number: {w[7:0], w}};
      @(posedge clk_sys);
      call_in <= '0;
      repeat (6) @(posedge clk_sys);
   endtask
   task automatic pulse(input logic [1:0] k, input int wait_n);
      act <= k;
      go <= 1'b1;
      @(posedge clk_sys);
      go <= 1'b0;
      repeat (wait_n) @(posedge clk_sys);
   endtask
   initial begin
      logic [31:0] p, h, xp, xh, xa, w, cfg, e;
      int a;
      int b;
      repeat (8) @(posedge clk_sys);
      reset_n <= 1'b1;
      @(posedge clk_sys);
      for (int i = 1; i < 8; i++) rd(8'(4 * i), 32'h0);
      rd(pdac_pkg::OFS_CTRL, 32'h101);
      rd(8'h30, 32'h0);
      for (int i = 0; i < 8; i++) begin
         cfg = {18'h0, 6'(i * 9), 1'b0, 3'(i), 1'b0, 2'(i), 1'b1};
         e = cfg;
         if (i == 0) e[13:8] = pdac_pkg::TMO_MIN;
         if (i == 7) e[13:8] = pdac_pkg::TMO_MAX;
         wr(pdac_pkg::OFS_CTRL, cfg);
         rd(pdac_pkg::OFS_CTRL, e);
      end
      cfg = 32'h101; // auto answer kept on, as a v35 port needs
      wr(pdac_pkg::OFS_MASK, 32'h0F);
      a = n_dial;
      wr(pdac_pkg::OFS_CTRL, cfg | 32'h10000);
      repeat (3) @(posedge clk_sys);
      chk(40'(n_dial - a), 40'h0);
      rd(pdac_pkg::OFS_IRQ, 32'h10);
      chk(40'(irq_q), 40'h0);
      wr(pdac_pkg::OFS_MASK, 32'h1F);
      repeat (2) @(posedge clk_sys);
      chk(40'(irq_q), 40'h1);
      wr(pdac_pkg::OFS_IRQ, 32'h10);
      repeat (2) @(posedge clk_sys);
      chk(40'(irq_q), 40'h0);
      p = bcd();
      h = bcd();
      xp = bcd();
      xh = bcd();
      xa = bcd();
      wr(pdac_pkg::OFS_PRIM, p);
      wr(pdac_pkg::OFS_HUNT, h);
      wr(pdac_pkg::OFS_XPRIM, xp);
      wr(pdac_pkg::OFS_XHUNT, xh);
      wr(pdac_pkg::OFS_XADD, xa);
      tmpl_data <= rnd();
      @(posedge clk_sys);
      wr(pdac_pkg::OFS_LOAD, 32'h3);
      rd(pdac_pkg::OFS_STAT, 32'h4);
      rd(pdac_pkg::OFS_PROF, tmpl_data);
      rd(pdac_pkg::OFS_IRQ, 32'h1);
      wr(pdac_pkg::OFS_IRQ, 32'h1F);
      for (int k = 0; k < 4; k++) begin
         cfg = {18'h0, 6'h01, 5'h0, 2'(k), 1'b1};
         wr(pdac_pkg::OFS_CTRL, cfg);
         a = n_dial;
         pulse(k == 0 ? 2'h1 : 2'(k), 12);
         chk(40'(n_dial - a), 40'(k != 0));
         wr(pdac_pkg::OFS_CTRL, cfg | 32'h10000);
         repeat (3) @(posedge clk_sys);
         chk(40'(n_dial - a), 40'h1);
         chk(calling_num_q, {p[7:0], p});
         wr(pdac_pkg::OFS_CTRL, cfg | 32'h20000);
         pulse(2'h0, 1);
         dtr_drop <= 1'b1;
         @(posedge clk_sys);
         dtr_drop <= 1'b0;
      end
      cfg = 32'h101;
      wr(pdac_pkg::OFS_CTRL, cfg);
      b = n_hang;
      // cases: own, group deferred, group, imux group no engine, imux group, imux own, foreign
      for (int c = 0; c < 7; c++) begin
         w = c == 0 ? p : c < 3 ? h : c < 5 ? xh : c == 5 ? xp : 32'h98989898;
         prior_port_free <= c == 1;
         engine_free <= c != 3;
         a = n_acc;
         call(c >= 3 && c != 6, w);
         chk(40'(n_acc - a), 40'(c != 1 && c != 3 && c != 6));
         if (c == 5) chk({sync_add_valid_q, sync_add_num_q}, {1'b1, xa[7:0], xa});
         if (c == 0) call(1'b0, p);
         if (c == 0) chk(40'(n_acc - a), 40'h1);
         if (c == 0) chk(40'(port_free_q), 40'h0);
         wr(pdac_pkg::OFS_CTRL, cfg | 32'h20000);
      end
      chk(40'(n_hang - b), 40'h4);
      wr(pdac_pkg::OFS_XADD, 32'h0);
      call(1'b1, xp);
      chk(40'(sync_add_valid_q), 40'h0);
      wr(pdac_pkg::OFS_CTRL, cfg | 32'h20000);
      cfg = 32'h200;
      wr(pdac_pkg::OFS_CTRL, cfg);
      a = n_acc;
      call(1'b0, p);
      chk(40'(ring_q), 40'h1);
      chk(40'(n_acc - a), 40'h0);
      rd(pdac_pkg::OFS_STAT, 32'h5);
      pulse(2'h1, 10);
      chk(40'(n_acc - a), 40'h1);
      wr(pdac_pkg::OFS_CTRL, cfg | 32'h20000);
      dtr_drop <= 1'b1;
      @(posedge clk_sys);
      dtr_drop <= 1'b0;
      // let the dropped dtr clear the synchroniser before the next offer
      repeat (3) @(posedge clk_sys);
      a = n_rej;
      call(1'b0, p);
      repeat (2 * SEC - 12) @(posedge clk_sys);
      chk(40'(n_rej - a), 40'h0);
      repeat (12) @(posedge clk_sys);
      chk(40'(n_rej - a), 40'h1);
      rd(pdac_pkg::OFS_STAT, 32'h4);
      chk(40'(port_free_q), 40'h1);
      end_of_test();
   end
endmodule
